// [rtl/channel_gain_filter_sampler.sv]
// Purpose: Per-phase gain, high-pass filter, current integrator and waveform capture
//          for three current and three voltage channels, with register port.
// Assumes: ADC words are synchronous to i_sys_clk and read at the sample tick.
// Notes:   Processed samples also leave through a two-entry buffer.
`include "cgfs_params.svh"
// Overview of operation
// - Current sample times one plus signed gain over two to the 23.
// - Gain 0x400000 raises amplitude by half, 0xC00000 lowers by half.
// - Current gain reaches every downstream result and the stored samples.
// - Gain and coefficient read as 28-bit sign extension, top four zero.
// - All high-pass filters on after reset; disable register resets to zero.
// - Any nonzero disable value bypasses every high-pass filter together.
// - Disable register reads with upper eight bits zero.
// - Current samples after the filter captured per phase at 8 kSPS.
// - Capturing samples never stalls the ongoing computations.
// - Data-ready flag, status bit 17, set when fresh samples exist.
// - Interrupt raised from data-ready only when mask bit 17 is set.
// - Sample registers read sign-extended to 32 bits.
// - Integrator off after reset, switched on by config bit 0.
// - Coefficient ignored while the integrator is off.
// - Integrator gives 20 dB per decade roll-off, about -90 degrees.
// - ADC delivers signed 24-bit words at 8 kSPS; full scale 0x5A7540.
// - Voltage sample times one plus signed gain over two to the 23.
// - Voltage gain reaches the output stream and the stored voltage samples.
// - Voltage samples after the filter captured at 8 kSPS, setting data-ready.
module channel_gain_filter_sampler #(
  parameter int SAMPLE_DIV = `SAMPLE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire cgfs_pkg::chan_set_s i_adc,
  input wire cgfs_pkg::reg_req_s i_reg,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_irq_n,
  output cgfs_pkg::chan_set_s o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  import cgfs_pkg::*;

  localparam int CW = $clog2(SAMPLE_DIV);

  if (SAMPLE_DIV < 16) begin : g_bad_div
    $error("SAMPLE_DIV too small for the processing sequence");
  end

  // Sample sequencing.
  logic [CW-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d, pend_q, pend_d, vld_q, vld_d, opend_q, opend_d;
  logic en, push, pop;
  // Registers.
  word_t [2:0] igain_q, igain_d, vgain_q, vgain_d;
  logic [23:0] hpd_q, hpd_d;
  word_t coef_q, coef_d;
  logic int_on_q, int_on_d, flag_q, flag_d, irq_n_d;
  logic [31:0] mask_q, mask_d, rdata_d;
  chan_set_s wave_q, wave_d, chan_y;
  logic hpf_off, clr;
  // Output buffer.
  chan_set_s e0_q, e0_d, e1_q, e1_d;
  logic v0_q, v0_d, v1_q, v1_d;

  assign hpf_off = |hpd_q;
  // Processing never waits for the stream, so capture keeps its rate; a result that
  // finds the buffer full is replaced by the next one while the two queued words stay.
  assign en = pend_q;
  assign push = opend_q && !v1_q;
  assign pop = v0_q && i_out_ready;

  always_comb begin
    cnt_d = cnt_q + CW'(1);
    tick_d = 1'b0;
    if (cnt_q == CW'(SAMPLE_DIV - 1)) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
    pend_d = tick_q || (pend_q && !en);
    vld_d = en;
    opend_d = vld_q || (opend_q && !push);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
      pend_q <= 1'b0;
      vld_q <= 1'b0;
      opend_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      pend_q <= pend_d;
      vld_q <= vld_d;
      opend_q <= opend_d;
    end
  end

  for (genvar k = 0; k < 3; k++) begin : g_phase
    chan_proc #(.W(24), .HAS_INT(1'b1)) u_cur (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_en(en),
      .i_x(i_adc.cur[k]),
      .i_gain(igain_q[k]),
      .i_coeff(coef_q),
      .i_hpf_off(hpf_off),
      .i_int_on(int_on_q),
      .o_y(chan_y.cur[k])
    );
    chan_proc #(.W(24), .HAS_INT(1'b0)) u_vol (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_en(en),
      .i_x(i_adc.vol[k]),
      .i_gain(vgain_q[k]),
      .i_coeff(coef_q),
      .i_hpf_off(hpf_off),
      .i_int_on(1'b0),
      .o_y(chan_y.vol[k])
    );
  end

  always_comb begin
    igain_d = igain_q;
    vgain_d = vgain_q;
    hpd_d = hpd_q;
    coef_d = coef_q;
    int_on_d = int_on_q;
    mask_d = mask_q;
    clr = 1'b0;
    if (i_reg.wr) begin
      case (i_reg.addr)
        `ADDR_IGAIN_A: igain_d[0] = i_reg.wdata[23:0];
        `ADDR_IGAIN_B: igain_d[1] = i_reg.wdata[23:0];
        `ADDR_IGAIN_C: igain_d[2] = i_reg.wdata[23:0];
        `ADDR_VGAIN_A: vgain_d[0] = i_reg.wdata[23:0];
        `ADDR_VGAIN_B: vgain_d[1] = i_reg.wdata[23:0];
        `ADDR_VGAIN_C: vgain_d[2] = i_reg.wdata[23:0];
        `ADDR_HPF_DIS: hpd_d = i_reg.wdata[23:0];
        `ADDR_INT_COEF: coef_d = i_reg.wdata[23:0];
        `ADDR_CONFIG: int_on_d = i_reg.wdata[`INT_ON_BIT];
        `ADDR_FLAGS: clr = i_reg.wdata[`READY_BIT];
        `ADDR_MASK: mask_d = i_reg.wdata;
        default: clr = 1'b0;
      endcase
    end
    // Capture runs off the processing strobe alone, so the buffer never holds it up.
    wave_d = vld_q ? chan_y : wave_q;
    // A fresh capture in the clearing cycle keeps the flag set.
    flag_d = vld_q || (flag_q && !clr);
    irq_n_d = !(flag_d && mask_d[`READY_BIT]);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      igain_q <= {3{`GAIN_RST}};
      vgain_q <= {3{`GAIN_RST}};
      hpd_q <= `HPF_DIS_RST;
      coef_q <= `COEF_RST;
      int_on_q <= 1'b0;
      mask_q <= 32'h0000_0000;
      wave_q <= '0;
      flag_q <= 1'b0;
      o_irq_n <= 1'b1;
    end else begin
      igain_q <= igain_d;
      vgain_q <= vgain_d;
      hpd_q <= hpd_d;
      coef_q <= coef_d;
      int_on_q <= int_on_d;
      mask_q <= mask_d;
      wave_q <= wave_d;
      flag_q <= flag_d;
      o_irq_n <= irq_n_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_reg.addr)
      `ADDR_IGAIN_A, `ADDR_IGAIN_B, `ADDR_IGAIN_C: begin
        rdata_d = {4'h0, {4{igain_q[i_reg.addr[1:0]][23]}}, igain_q[i_reg.addr[1:0]]};
      end
      `ADDR_VGAIN_A, `ADDR_VGAIN_B, `ADDR_VGAIN_C: begin
        rdata_d = {4'h0, {4{vgain_q[2'(i_reg.addr - `ADDR_VGAIN_A)][23]}},
          vgain_q[2'(i_reg.addr - `ADDR_VGAIN_A)]};
      end
      `ADDR_HPF_DIS: rdata_d = {8'h00, hpd_q};
      `ADDR_INT_COEF: rdata_d = {4'h0, {4{coef_q[23]}}, coef_q};
      `ADDR_CONFIG: rdata_d = {31'h0, int_on_q};
      `ADDR_FLAGS: rdata_d = 32'(flag_q) << `READY_BIT;
      `ADDR_MASK: rdata_d = mask_q;
      `ADDR_WAVE_IA, 5'h0C, 5'h0D: begin
        rdata_d = 32'(wave_q.cur[2'(i_reg.addr - `ADDR_WAVE_IA)]);
      end
      `ADDR_WAVE_VA, 5'h0F, 5'h10: begin
        rdata_d = 32'(wave_q.vol[2'(i_reg.addr - `ADDR_WAVE_VA)]);
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg.rd ? rdata_d : o_reg_rdata;
      o_reg_rvalid <= i_reg.rd;
    end
  end

  always_comb begin
    e0_d = e0_q;
    e1_d = e1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop) begin
      e0_d = e1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (push) begin
      if (!v0_d) begin
        e0_d = chan_y;
        v0_d = 1'b1;
      end else begin
        e1_d = chan_y;
        v1_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      e0_q <= '0;
      e1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      e0_q <= e0_d;
      e1_q <= e1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end

  assign o_out_data = e0_q;
  assign o_out_valid = v0_q;

  a_gain_pad: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.rd && i_reg.addr <= `ADDR_VGAIN_C |=> o_reg_rdata[31:28] == 4'h0
    && (o_reg_rdata[27:23] == 5'h1F || o_reg_rdata[27:23] == 5'h00))
    else $error("gain readback not padded and sign extended");
  a_hpd_pad: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.rd && i_reg.addr == `ADDR_HPF_DIS |=> o_reg_rdata == {8'h00, $past(hpd_q)})
    else $error("filter disable readback wrong");
  a_wave_sext: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.rd && i_reg.addr >= `ADDR_WAVE_IA && i_reg.addr <= 5'h10
    |=> o_reg_rdata[31:24] == {8{o_reg_rdata[23]}})
    else $error("sample readback not sign extended");
  a_ready_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    en |=> ##1 flag_q && wave_q == $past(chan_y))
    else $error("capture did not set data-ready");
  a_w1c_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.wr && i_reg.addr == `ADDR_FLAGS && i_reg.wdata[`READY_BIT] && !vld_q
    |=> !flag_q && o_irq_n)
    else $error("write one did not clear data-ready and interrupt");
  a_irq_mask: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_irq_n == !(flag_q && mask_q[`READY_BIT]))
    else $error("interrupt does not follow flag and mask");
  a_int_cfg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.wr && i_reg.addr == `ADDR_CONFIG |=> int_on_q == $past(i_reg.wdata[0]))
    else $error("integrator enable not taken from config bit 0");
  a_hpd_any: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg.wr && i_reg.addr == `ADDR_HPF_DIS && i_reg.wdata[23:0] != 24'h0 |=> hpf_off)
    else $error("nonzero disable value did not bypass the filters");
  a_tick_gap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick_q |=> !tick_q [*8])
    else $error("sample ticks too close");
  a_no_stall: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick_q |=> ##1 vld_q)
    else $error("capture held up");
  c_capture: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) vld_q);
  c_irq: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) !o_irq_n);
  c_full: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) v1_q && !i_out_ready);
  c_fscale: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    en && i_adc.cur[2] == `FULL_SCALE);
endmodule // channel_gain_filter_sampler

// [shared/cgfs_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the
//          channel gain, filter and sampling block.
// Assumes: Register offsets are word indices on the device's internal
//          register port behind the serial interface.
// Notes:   Definitions only.
`ifndef CGFS_PARAMS_SVH
`define CGFS_PARAMS_SVH
`define CLK_HZ 100000000
`define SAMPLE_HZ 8000
`define SAMPLE_CYCLES (`CLK_HZ / `SAMPLE_HZ)
`define ADDR_IGAIN_A 5'h00
`define ADDR_IGAIN_B 5'h01
`define ADDR_IGAIN_C 5'h02
`define ADDR_VGAIN_A 5'h03
`define ADDR_VGAIN_B 5'h04
`define ADDR_VGAIN_C 5'h05
`define ADDR_HPF_DIS 5'h06
`define ADDR_INT_COEF 5'h07
`define ADDR_CONFIG 5'h08
`define ADDR_FLAGS 5'h09
`define ADDR_MASK 5'h0A
`define ADDR_WAVE_IA 5'h0B
`define ADDR_WAVE_VA 5'h0E
`define READY_BIT 17
`define INT_ON_BIT 0
`define GAIN_RST 24'h000000
`define HPF_DIS_RST 24'h000000
`define COEF_RST 24'h000000
`define COEF_FRAC 23
`define GAIN_FRAC 23
`define HPF_SHIFT 10
`define INT_SHIFT 5
`define FULL_SCALE 24'h5A7540
`endif

// [shared/cgfs_pkg.sv]
// Purpose: Types shared by the channel gain, filter and sampling block.
// Assumes: Six channels: three phase currents and three phase voltages.
// Notes:   Channel index 0, 1, 2 is phase A, B, C.
package cgfs_pkg;
  typedef logic signed [23:0] word_t;
  typedef struct packed {
    word_t [2:0] cur;
    word_t [2:0] vol;
  } chan_set_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage

// [rtl/chan_proc.sv]
// Purpose: One channel: high-pass filter, optional integrator, gain.
// Assumes: i_en is a one-cycle pulse per sample; i_x is valid with it.
// Notes:   o_y updates one cycle after i_en and holds until the next one.
`include "cgfs_params.svh"
module chan_proc #(
  parameter int W = 24,
  parameter bit HAS_INT = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic signed [W-1:0] i_x,
  input wire logic signed [W-1:0] i_gain,
  input wire logic signed [W-1:0] i_coeff,
  input wire logic i_hpf_off,
  input wire logic i_int_on,
  output logic signed [W-1:0] o_y
);
  localparam int AW = W + 8;
  logic signed [W-1:0] xp_q, xp_d, hp_q, hp_d, y_d;
  logic signed [AW-1:0] acc_q, acc_d;
  logic signed [63:0] t, m;
  logic int_en;

  function automatic logic signed [63:0] clip(input logic signed [63:0] v, input int b);
    logic signed [63:0] hi;
    hi = (64'sd1 <<< (b - 1)) - 64'sd1;
    clip = (v > hi) ? hi : (v < -hi - 64'sd1) ? -hi - 64'sd1 : v;
  endfunction

  assign int_en = HAS_INT && i_int_on;

  always_comb begin
    xp_d = xp_q;
    hp_d = hp_q;
    acc_d = acc_q;
    y_d = o_y;
    t = 64'sd0;
    m = 64'sd0;
    if (i_en) begin
      xp_d = i_x;
      t = 64'(i_x) - 64'(xp_q) + 64'(hp_q) - (64'(hp_q) >>> `HPF_SHIFT);
      hp_d = i_hpf_off ? i_x : W'(clip(t, W));
      m = 64'(hp_d);
      if (int_en) begin
        // Leaky accumulator; a negative coefficient sets the leak so dc cannot wind it up.
        t = 64'(acc_q) + m + ((64'(acc_q) * 64'(i_coeff)) >>> `COEF_FRAC);
        acc_d = AW'(clip(t, AW));
        m = clip(64'(acc_d) >>> `INT_SHIFT, W);
      end else begin
        acc_d = '0;
      end
      y_d = W'(clip(m + ((m * 64'(i_gain)) >>> `GAIN_FRAC), W));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xp_q <= '0;
      hp_q <= '0;
      acc_q <= '0;
      o_y <= '0;
    end else begin
      xp_q <= xp_d;
      hp_q <= hp_d;
      acc_q <= acc_d;
      o_y <= y_d;
    end
  end

  a_unity_gain: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_en && i_hpf_off && !int_en && i_gain == '0 |=> o_y == $past(i_x))
    else $error("zero gain did not pass the sample unchanged");
  a_half_up: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_en && i_hpf_off && !int_en && i_gain == 24'sh400000 && i_x <= 24'sh100000
    && i_x >= -24'sh100000 |=> o_y == $past(i_x + (i_x >>> 1)))
    else $error("gain 0x400000 did not raise the sample by half");
  a_half_down: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_en && i_hpf_off && !int_en && i_gain == 24'shC00000 && i_x <= 24'sh100000
    && i_x >= -24'sh100000 |=> o_y == $past(i_x + ((-i_x) >>> 1)))
    else $error("gain 0xC00000 did not lower the sample by half");
endmodule // chan_proc

// [tb/cgfs_partner.sv]
// Purpose: Far side of the block: converter word source and output stream sink.
// Assumes: The bench sets the words and the stall mode; changes land at the falling edge.
// Notes: Slow mode accepts a word only every other cycle.
module cgfs_partner (
  input wire logic i_sys_clk,
  input wire cgfs_pkg::chan_set_s i_words,
  input wire logic i_stall,
  input wire logic i_slow,
  output cgfs_pkg::chan_set_s o_adc,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import cgfs_pkg::*;
  logic phase_q = 1'b0;
  initial begin
    o_adc = '0;
    o_ready = 1'b0;
  end
  // Words are held for whole sample periods, so any capture instant sees the same code.
  always @(negedge i_sys_clk) begin
    o_adc <= i_words;
    phase_q <= ~phase_q;
    o_ready <= ~i_stall && (~i_slow || phase_q);
  end
endmodule // cgfs_partner

// [tb/test_channel_gain_filter_sampler.sv]
// Purpose: Self-checking bench for the channel gain, filter and sampling block.
// Assumes: Sample divider shortened to 64 cycles; inputs change at the falling edge.
// Notes: Converter words stay constant, so captures of one setup are equal while filters and integrator are bypassed.
`include "cgfs_params.svh"
module test_channel_gain_filter_sampler;
  timeunit 1ns;
  timeprecision 1ps;
  import cgfs_pkg::*;
  localparam int LIMIT = 20000;
  logic i_sys_clk;
  logic i_rst_n;
  chan_set_s words;
  chan_set_s adc;
  chan_set_s out_data;
  chan_set_s held;
  reg_req_s req;
  logic [31:0] rdata;
  logic [31:0] s;
  logic rvalid;
  logic irq_n;
  logic out_valid;
  logic ready;
  logic stall;
  logic slow;
  int n_errors;
  int tests_run;
  int cycles;
  int i;
  word_t gtab [3];
  word_t yexp [6];

  channel_gain_filter_sampler #(.SAMPLE_DIV(64)) dut (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_adc(adc),
    .i_reg(req),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .o_irq_n(irq_n),
    .o_out_data(out_data),
    .o_out_valid(out_valid),
    .i_out_ready(ready)
  );
  cgfs_partner far_end (
    .i_sys_clk(i_sys_clk),
    .i_words(words),
    .i_stall(stall),
    .i_slow(slow),
    .o_adc(adc),
    .o_ready(ready)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge i_sys_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_sys_clk);
    req = '0;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
    int k;
    @(negedge i_sys_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge i_sys_clk);
    req = '0;
    for (k = 0; k < 3 && rvalid !== 1'b1; k++) begin
      @(negedge i_sys_clk);
    end
    check("read answer", {31'h0, rvalid}, 32'h1);
    d = rdata;
  endtask
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    check(what, d, exp);
  endtask
  // Clearing first means the flag seen afterwards comes from a capture after this call.
  task automatic next_set();
    logic [31:0] f;
    int k;
    reg_wr(`ADDR_FLAGS, 32'h1 << `READY_BIT);
    f = '0;
    for (k = 0; k < 60 && f[`READY_BIT] !== 1'b1; k++) begin
      reg_rd(`ADDR_FLAGS, f);
    end
    check("flag set", {31'h0, f[`READY_BIT]}, 32'h1);
  endtask
  task automatic fresh();
    next_set();
    next_set();
  endtask
  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
  endtask

  task automatic t_reset();
    rd_chk("flags reset", `ADDR_FLAGS, 32'h0);
    check("irq reset", {31'h0, irq_n}, 32'h1);
    rd_chk("config reset", `ADDR_CONFIG, 32'h0);
    rd_chk("disable reset", `ADDR_HPF_DIS, 32'h0);
    rd_chk("coeff reset", `ADDR_INT_COEF, 32'h0);
    rd_chk("gain reset", `ADDR_VGAIN_C, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (i = 0; i < 6; i++) begin
      reg_wr(5'(`ADDR_IGAIN_A + i), {8'hA5, gtab[i % 3]});
      rd_chk("gain read", 5'(`ADDR_IGAIN_A + i), {4'h0, {4{gtab[i % 3][23]}}, gtab[i % 3]});
    end
    reg_wr(`ADDR_INT_COEF, 32'hFF7FFFFF);
    rd_chk("coeff read", `ADDR_INT_COEF, 32'h007FFFFF);
    reg_wr(`ADDR_HPF_DIS, 32'hFFFFFFFF);
    rd_chk("disable read", `ADDR_HPF_DIS, 32'h00FFFFFF);
    reg_wr(5'h1F, 32'hFFFFFFFF);
    rd_chk("unmapped read", 5'h1F, 32'h0);
    $display("test registers done");
  endtask
  // Filters bypassed and a nonzero coefficient left in place with the integrator off.
  task automatic t_gain();
    slow = 1'b1;
    fresh();
    for (i = 0; i < 6; i++) begin
      rd_chk("sample", 5'(`ADDR_WAVE_IA + i), {{8{yexp[i][23]}}, yexp[i]});
    end
    $display("test gain done");
  endtask
  task automatic t_stall();
    stall = 1'b1;
    fresh();
    next_set();
    check("stall valid", {31'h0, out_valid}, 32'h1);
    held = out_data;
    next_set();
    check("stall hold", {31'h0, out_data === held}, 32'h1);
    for (i = 0; i < 3; i++) begin
      check("stream cur", {8'h0, out_data.cur[i]}, {8'h0, yexp[i]});
      check("stream vol", {8'h0, out_data.vol[i]}, {8'h0, yexp[i + 3]});
    end
    stall = 1'b0;
    slow = 1'b0;
    for (i = 0; i < 20 && out_valid === 1'b1; i++) begin
      @(negedge i_sys_clk);
    end
    check("drained", {31'h0, out_valid}, 32'h0);
    $display("test stall done");
  endtask
  task automatic t_hpf();
    reg_wr(`ADDR_HPF_DIS, 32'h0);
    fresh();
    reg_rd(`ADDR_WAVE_IA, s);
    check("filter on", {31'h0, s !== 32'h00180000}, 32'h1);
    reg_wr(`ADDR_HPF_DIS, 32'h00000100);
    fresh();
    rd_chk("filter off", `ADDR_WAVE_IA, 32'h00180000);
    $display("test filter done");
  endtask
  task automatic t_integ();
    reg_wr(`ADDR_INT_COEF, 32'h00FF8000);
    reg_wr(`ADDR_CONFIG, 32'h1 << `INT_ON_BIT);
    fresh();
    reg_rd(`ADDR_WAVE_IA, s);
    check("integrator on", {31'h0, s !== 32'h00180000}, 32'h1);
    rd_chk("voltage path", `ADDR_WAVE_VA, 32'hFFE80000);
    reg_wr(`ADDR_CONFIG, 32'h0);
    fresh();
    rd_chk("integrator off", `ADDR_WAVE_IA, 32'h00180000);
    $display("test integrator done");
  endtask
  task automatic t_irq();
    next_set();
    check("irq masked", {31'h0, irq_n}, 32'h1);
    reg_wr(`ADDR_MASK, 32'h1 << `READY_BIT);
    repeat (2) @(negedge i_sys_clk);
    check("irq raised", {31'h0, irq_n}, 32'h0);
    reg_wr(`ADDR_FLAGS, 32'h1 << `READY_BIT);
    check("irq released", {31'h0, irq_n}, 32'h1);
    rd_chk("flag cleared", `ADDR_FLAGS, 32'h0);
    next_set();
    repeat (2) @(negedge i_sys_clk);
    check("irq again", {31'h0, irq_n}, 32'h0);
    do_reset();
    check("irq after reset", {31'h0, irq_n}, 32'h1);
    rd_chk("disable after reset", `ADDR_HPF_DIS, 32'h0);
    $display("test interrupt done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    req = '0;
    i_rst_n = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    words.cur = {`FULL_SCALE, 24'h100000, 24'h100000};
    words.vol = {24'hA58AC0, 24'hF00000, 24'hF00000};
    gtab = '{24'h400000, 24'hC00000, 24'h000000};
    yexp = '{24'h180000, 24'h080000, 24'h5A7540, 24'hE80000, 24'hF80000, 24'hA58AC0};
    do_reset();
    t_reset();
    t_regs();
    t_gain();
    t_stall();
    t_hpf();
    t_integ();
    t_irq();
    close_out();
  end
endmodule // test_channel_gain_filter_sampler
